/* File: pkg/snlc_pkg.sv */
`default_nettype none
package snlc_pkg;
  // Clock and timing
  localparam int CLK_HZ = 10_000_000;
  localparam int LISTEN_MS = 250;
  localparam int LISTEN_CYC = LISTEN_MS * (CLK_HZ / 1000);
  localparam int ACK_WAIT_US = 2000;
  localparam int ACK_WAIT_CYC = ACK_WAIT_US * (CLK_HZ / 1_000_000);
  // Network addresses
  localparam logic [15:0] BASE_ADDR = 16'h0000;
  localparam logic [15:0] REM_ADDR_MIN = 16'h0001;
  localparam logic [15:0] REM_ADDR_MAX = 16'h003F;
  localparam logic [15:0] BCAST_ADDR = 16'hFFFF;
  localparam int ADDR_FIELD_W = 6;
  localparam int MAX_REMOTES = 63;
  // Frame kinds on the radio side
  localparam logic [2:0] K_DATA = 3'h0;
  localparam logic [2:0] K_ACK = 3'h1;
  localparam logic [2:0] K_JOIN_REQ = 3'h2;
  localparam logic [2:0] K_JOIN_REPLY = 3'h3;
  localparam logic [2:0] K_REG_REQ = 3'h4;
  localparam logic [2:0] K_REG_REPLY = 3'h5;
  localparam logic [2:0] K_REG_DENY = 3'h6;
  // Host notice kinds
  localparam logic [1:0] N_NONE = 2'h0;
  localparam logic [1:0] N_CONFLICT = 2'h1;
  localparam logic [1:0] N_CONNECT = 2'h2;
  // Register offsets
  localparam logic [3:0] RA_CTRL = 4'h0;
  localparam logic [3:0] RA_PAN = 4'h1;
  localparam logic [3:0] RA_CHANS = 4'h2;
  localparam logic [3:0] RA_RETRY = 4'h3;
  localparam logic [3:0] RA_BREPS = 4'h4;
  localparam logic [3:0] RA_FLOOR = 4'h5;
  localparam logic [3:0] RA_STATUS = 4'h6;
  localparam logic [3:0] RA_ADDR = 4'h7;
  // Field positions
  localparam int CTRL_BASE_BIT = 0;
  localparam int CTRL_ANY_BIT = 1;
  localparam int CTRL_EN_BIT = 2;
  localparam int ST_LINK_BIT = 15;
  localparam int ST_CHAN_LSB = 8;
  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] PAN_RST = 16'h0000;
  localparam logic [15:0] CHANS_RST = 16'hFFFF;
  localparam logic [3:0] RETRY_RST = 4'h3;
  localparam logic [3:0] BREPS_RST = 4'h4;
  localparam logic [7:0] FLOOR_RST = 8'h00;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  // State machines
  typedef enum logic [2:0] {E_IDLE, E_SENSE, E_CCA, E_BACKOFF, E_SEND,
    E_ACK} snlc_eng_t;
  typedef enum logic [2:0] {F_OFF, F_B_LISTEN, F_B_RUN, F_R_JOIN,
    F_R_LISTEN, F_R_REG, F_R_WAIT, F_R_LINKED} snlc_form_t;
endpackage
`default_nettype wire

/* File: design/snlc_top.sv */
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module snlc_top
  import snlc_pkg::*;
#(
  parameter int LISTEN_CYCLES = snlc_pkg::LISTEN_CYC,
  parameter int ACK_CYCLES = snlc_pkg::ACK_WAIT_CYC,
  parameter int TMR_W = 22,
  parameter int BO_W = 10,
  parameter int MAC_W = 64
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [MAC_W-1:0] own_mac,
  input wire logic host_tx_req,
  input wire logic [15:0] host_tx_dst,
  input wire logic [15:0] host_tx_arg,
  output logic host_tx_ready,
  output logic host_tx_ok,
  output logic host_tx_fail,
  output logic cca_req,
  input wire logic cca_done,
  input wire logic cca_busy,
  output logic phy_tx_start,
  output logic [2:0] phy_tx_kind,
  output logic [15:0] phy_tx_dst,
  output logic [15:0] phy_tx_src,
  output logic [15:0] phy_tx_pan,
  output logic [7:0] phy_tx_seq,
  output logic [15:0] phy_tx_arg,
  output logic [MAC_W-1:0] phy_tx_mac,
  output logic phy_tx_relay,
  input wire logic phy_tx_done,
  input wire logic rx_valid,
  input wire logic [2:0] rx_kind,
  input wire logic [15:0] rx_src,
  input wire logic [15:0] rx_dst,
  input wire logic [15:0] rx_pan,
  input wire logic [7:0] rx_seq,
  input wire logic [7:0] rx_power,
  input wire logic [15:0] rx_arg,
  input wire logic [MAC_W-1:0] rx_mac,
  output logic rx_deliver,
  output logic [15:0] rx_out_src,
  output logic [15:0] rx_out_arg,
  output logic [3:0] chan_sel,
  output logic [15:0] node_addr,
  output logic linked,
  output logic notice_valid,
  output logic [1:0] notice_kind,
  output logic [3:0] notice_chan,
  output logic [15:0] notice_pan
);
  import snlc_pkg::*;

  // Next enabled channel after cur, wrapping; cur if mask is empty
  function automatic logic [3:0] next_chan(input logic [15:0] mask,
                                           input logic [3:0] cur);
    logic [3:0] idx;
    logic hit;
    next_chan = cur;
    hit = 1'b0;
    for (int i = 1; i <= 16; i++)
    begin
      idx = 4'(cur + 4'(i));
      if (!hit && mask[idx])
      begin
        next_chan = idx;
        hit = 1'b1;
      end
    end
  endfunction

  logic [2:0] ctrl_r;
  logic [15:0] pan_r, chans_r, node_addr_r, join_pan_r;
  logic [3:0] retry_r, breps_r, chan_r, found_chan_r;
  logic [7:0] floor_r, seq_r;
  logic [15:0] rdata_r, lfsr_r;
  logic cfg_chg, is_base, any_pan, enabled;
  snlc_eng_t eng_st;
  snlc_form_t fst;
  logic [TMR_W-1:0] etmr_r, ftmr_r;
  logic [BO_W-1:0] bo_r;
  logic [3:0] att_r, rep_r;
  logic relay_r, cur_host_r, eng_ok, eng_fail, found_r, linked_r;
  logic [2:0] cur_kind_r, ctl_kind_r;
  logic [15:0] cur_dst_r, cur_arg_r, ctl_dst_r, ctl_arg_r, ack_dst_r;
  logic [7:0] cur_seq_r, ack_seq_r;
  logic [MAC_W-1:0] cur_mac_r, ctl_mac_r;
  logic ack_pend_r, ctl_pend_r, ack_set, ack_take, ctl_set, ctl_take;
  logic [2:0] ctl_kind_nxt;
  logic [15:0] ctl_dst_nxt, ctl_arg_nxt;
  logic [MAC_W-1:0] tbl_mac [MAX_REMOTES];
  logic [MAX_REMOTES-1:0] tbl_vld_r;
  logic [5:0] reg_cnt_r, hit_idx, free_idx;
  logic tbl_hit, tbl_free, tbl_we;
  logic [15:0] last_src_r;
  logic [7:0] last_seq_r;
  logic last_vld_r;
  logic pan_ok, mac_ok, rx_dup, host_take;
  logic cap_hit;

  assign is_base = ctrl_r[CTRL_BASE_BIT];
  assign any_pan = ctrl_r[CTRL_ANY_BIT];
  assign enabled = ctrl_r[CTRL_EN_BIT];
  assign cfg_chg = reg_wr && (reg_addr == RA_CTRL || reg_addr == RA_PAN ||
                              reg_addr == RA_CHANS);

  // Register writes; cfg_chg restarts network formation
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= CTRL_RST;
      pan_r <= PAN_RST;
      chans_r <= CHANS_RST;
      retry_r <= RETRY_RST;
      breps_r <= BREPS_RST;
      floor_r <= FLOOR_RST;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        RA_CTRL: ctrl_r <= reg_wdata[2:0];
        RA_PAN: pan_r <= reg_wdata;
        RA_CHANS: chans_r <= reg_wdata;
        RA_RETRY: retry_r <= reg_wdata[3:0];
        RA_BREPS: breps_r <= reg_wdata[3:0];
        RA_FLOOR: floor_r <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 16'h0000;
    else if (!reg_rd)
      rdata_r <= 16'h0000;
    else
    begin
      unique case (reg_addr)
        RA_CTRL: rdata_r <= {13'h0000, ctrl_r};
        RA_PAN: rdata_r <= pan_r;
        RA_CHANS: rdata_r <= chans_r;
        RA_RETRY: rdata_r <= {12'h000, retry_r};
        RA_BREPS: rdata_r <= {12'h000, breps_r};
        RA_FLOOR: rdata_r <= {8'h00, floor_r};
        RA_STATUS: rdata_r <= {linked_r, 3'h0, chan_r, 2'h0, reg_cnt_r};
        RA_ADDR: rdata_r <= node_addr_r;
        default: rdata_r <= 16'h0000;
      endcase
    end
  end
  assign reg_rdata = rdata_r;

  // Free-running LFSR for backoff intervals
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lfsr_r <= LFSR_SEED;
    else
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^
                 lfsr_r[10]};
  end

  // Acks jump ahead of all other frames so the sender's timer holds
  assign host_tx_ready = (eng_st == E_IDLE) && !ack_pend_r &&
                         !ctl_pend_r && linked_r;
  assign host_take = host_tx_req && host_tx_ready;
  assign ack_take = (eng_st == E_IDLE) && ack_pend_r;
  assign ctl_take = (eng_st == E_IDLE) && !ack_pend_r && ctl_pend_r;
  assign cap_hit = (5'(att_r) + 5'h01) >= {1'b0, retry_r};
  assign cca_req = (eng_st == E_SENSE);

  // Channel access, retry and broadcast repeat engine
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eng_st <= E_IDLE;
      etmr_r <= '0;
      bo_r <= '0;
      att_r <= 4'h0;
      rep_r <= 4'h0;
      relay_r <= 1'b0;
      cur_host_r <= 1'b0;
      cur_kind_r <= K_DATA;
      cur_dst_r <= BCAST_ADDR;
      cur_arg_r <= 16'h0000;
      cur_seq_r <= 8'h00;
      cur_mac_r <= '0;
      seq_r <= 8'h00;
      eng_ok <= 1'b0;
      eng_fail <= 1'b0;
      phy_tx_start <= 1'b0;
    end
    else
    begin
      eng_ok <= 1'b0;
      eng_fail <= 1'b0;
      phy_tx_start <= 1'b0;
      unique case (eng_st)
        E_IDLE:
        begin
          att_r <= 4'h0;
          rep_r <= 4'h0;
          relay_r <= 1'b0;
          if (ack_take)
          begin
            cur_kind_r <= K_ACK;
            cur_dst_r <= ack_dst_r;
            cur_seq_r <= ack_seq_r;
            cur_host_r <= 1'b0;
            eng_st <= E_SENSE;
          end
          else if (ctl_take || host_take)
          begin
            cur_kind_r <= ctl_take ? ctl_kind_r : K_DATA;
            cur_dst_r <= ctl_take ? ctl_dst_r : host_tx_dst;
            cur_arg_r <= ctl_take ? ctl_arg_r : host_tx_arg;
            cur_mac_r <= ctl_take ? ctl_mac_r : own_mac;
            cur_seq_r <= seq_r;
            seq_r <= 8'(seq_r + 8'h01);
            cur_host_r <= !ctl_take;
            eng_st <= E_SENSE;
          end
        end
        E_SENSE: eng_st <= E_CCA;
        E_CCA:
          if (cca_done && cca_busy)
          begin
            bo_r <= lfsr_r[BO_W-1:0];
            eng_st <= E_BACKOFF;
          end
          else if (cca_done)
          begin
            phy_tx_start <= 1'b1;
            eng_st <= E_SEND;
          end
        E_BACKOFF:
          if (bo_r == '0)
            eng_st <= E_SENSE;
          else
            bo_r <= bo_r - 1'b1;
        E_SEND:
          if (phy_tx_done)
          begin
            if (cur_kind_r == K_ACK || cur_kind_r == K_JOIN_REQ ||
                cur_kind_r == K_JOIN_REPLY)
            begin
              eng_ok <= 1'b1;
              eng_st <= E_IDLE;
            end
            else if (cur_dst_r == BCAST_ADDR)
            begin
              // Copies go out regardless of outcome, no ack wait
              if ((5'(rep_r) + 5'h01) >= {1'b0, breps_r})
              begin
                eng_ok <= 1'b1;
                eng_st <= E_IDLE;
              end
              else
              begin
                rep_r <= 4'(rep_r + 4'h1);
                eng_st <= E_SENSE;
              end
            end
            else
            begin
              etmr_r <= TMR_W'(ACK_CYCLES - 1);
              eng_st <= E_ACK;
            end
          end
        E_ACK:
          if (rx_valid && rx_kind == K_ACK && rx_seq == cur_seq_r &&
              rx_dst == node_addr_r)
          begin
            eng_ok <= 1'b1;
            eng_st <= E_IDLE;
          end
          else if (etmr_r != '0)
            etmr_r <= etmr_r - 1'b1;
          else if (!cap_hit)
          begin
            att_r <= 4'(att_r + 4'h1);
            eng_st <= E_SENSE;
          end
          else if (!relay_r)
          begin
            relay_r <= 1'b1;
            att_r <= 4'h0;
            eng_st <= E_SENSE;
          end
          else
          begin
            eng_fail <= 1'b1;
            eng_st <= E_IDLE;
          end
        default: eng_st <= E_IDLE;
      endcase
    end
  end

  // Registration table lookup by MAC
  always_comb
  begin
    tbl_hit = 1'b0;
    tbl_free = 1'b0;
    hit_idx = 6'h00;
    free_idx = 6'h00;
    for (int i = 0; i < MAX_REMOTES; i++)
    begin
      if (!tbl_hit && tbl_vld_r[i] && tbl_mac[i] == rx_mac)
      begin
        tbl_hit = 1'b1;
        hit_idx = 6'(i);
      end
      if (!tbl_free && !tbl_vld_r[i])
      begin
        tbl_free = 1'b1;
        free_idx = 6'(i);
      end
    end
  end

  assign pan_ok = any_pan || (rx_pan == pan_r);
  assign mac_ok = (rx_mac == own_mac);

  // Frames the formation and registration logic want sent
  always_comb
  begin
    ctl_set = 1'b0;
    tbl_we = 1'b0;
    ctl_kind_nxt = K_JOIN_REQ;
    ctl_dst_nxt = BCAST_ADDR;
    ctl_arg_nxt = 16'h0000;
    if (!ctl_pend_r)
    begin
      if (fst == F_R_JOIN)
        ctl_set = 1'b1;
      else if (fst == F_R_REG)
      begin
        ctl_set = 1'b1;
        ctl_kind_nxt = K_REG_REQ;
        ctl_dst_nxt = BASE_ADDR;
      end
      else if (fst == F_B_RUN && rx_valid && rx_pan == pan_r)
      begin
        if (rx_kind == K_JOIN_REQ)
        begin
          ctl_set = 1'b1;
          ctl_kind_nxt = K_JOIN_REPLY;
          ctl_dst_nxt = rx_src;
        end
        else if (rx_kind == K_REG_REQ && rx_dst == BASE_ADDR)
        begin
          ctl_set = 1'b1;
          ctl_kind_nxt = (tbl_hit || tbl_free) ? K_REG_REPLY : K_REG_DENY;
          tbl_we = !tbl_hit && tbl_free;
          ctl_arg_nxt = {{(16-ADDR_FIELD_W){1'b0}},
                         6'((tbl_hit ? hit_idx : free_idx) + 6'h01)};
          ctl_dst_nxt = (ctl_kind_nxt == K_REG_REPLY) ? ctl_arg_nxt : rx_src;
        end
      end
    end
  end

  // Ack requests for received directed frames
  always_comb
  begin
    ack_set = 1'b0;
    if (rx_valid && (!ack_pend_r || ack_take))
    begin
      if (rx_kind == K_DATA && linked_r && rx_dst == node_addr_r &&
          rx_dst != BCAST_ADDR)
        ack_set = 1'b1;
      else if (rx_kind == K_REG_REQ && fst == F_B_RUN &&
               rx_pan == pan_r && rx_dst == BASE_ADDR)
        ack_set = 1'b1;
      else if (rx_kind == K_REG_REPLY && fst == F_R_WAIT && mac_ok)
        ack_set = 1'b1;
    end
  end

  // Pending slots; a new request wins over the take
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_pend_r <= 1'b0;
      ack_dst_r <= BCAST_ADDR;
      ack_seq_r <= 8'h00;
      ctl_pend_r <= 1'b0;
      ctl_kind_r <= K_JOIN_REQ;
      ctl_dst_r <= BCAST_ADDR;
      ctl_arg_r <= 16'h0000;
      ctl_mac_r <= '0;
    end
    else
    begin
      if (ack_set)
      begin
        ack_pend_r <= 1'b1;
        ack_dst_r <= rx_src;
        ack_seq_r <= rx_seq;
      end
      else if (ack_take)
        ack_pend_r <= 1'b0;
      if (ctl_set)
      begin
        ctl_pend_r <= 1'b1;
        ctl_kind_r <= ctl_kind_nxt;
        ctl_dst_r <= ctl_dst_nxt;
        ctl_arg_r <= ctl_arg_nxt;
        ctl_mac_r <= is_base ? rx_mac : own_mac;
      end
      else if (ctl_take)
        ctl_pend_r <= 1'b0;
    end
  end

  // Persistent address table; only cleared by reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tbl_vld_r <= '0;
      reg_cnt_r <= 6'h00;
    end
    else if (tbl_we)
    begin
      tbl_vld_r[free_idx] <= 1'b1;
      reg_cnt_r <= 6'(reg_cnt_r + 6'h01);
    end
  end

  // Table storage needs no reset; valid bits guard it
  always_ff @(posedge clk)
  begin
    if (tbl_we)
      tbl_mac[free_idx] <= rx_mac;
  end

  // Network formation for both roles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fst <= F_OFF;
      ftmr_r <= '0;
      chan_r <= 4'h0;
      found_r <= 1'b0;
      found_chan_r <= 4'h0;
      join_pan_r <= PAN_RST;
      node_addr_r <= BCAST_ADDR;
      linked_r <= 1'b0;
    end
    else if (cfg_chg || !enabled)
    begin
      fst <= F_OFF;
      linked_r <= 1'b0;
    end
    else
    begin
      if (ftmr_r != '0)
        ftmr_r <= ftmr_r - 1'b1;
      unique case (fst)
        F_OFF:
          if (chans_r != 16'h0000)
          begin
            chan_r <= next_chan(chans_r, 4'hF);
            found_r <= 1'b0;
            ftmr_r <= TMR_W'(LISTEN_CYCLES - 1);
            node_addr_r <= is_base ? BASE_ADDR : BCAST_ADDR;
            fst <= is_base ? F_B_LISTEN : F_R_JOIN;
          end
        F_B_LISTEN:
          if (rx_valid && rx_pan == pan_r)
          begin
            chan_r <= next_chan(chans_r, chan_r);
            ftmr_r <= TMR_W'(LISTEN_CYCLES - 1);
          end
          else if (ftmr_r == '0)
          begin
            linked_r <= 1'b1;
            fst <= F_B_RUN;
          end
        F_B_RUN: ;
        F_R_JOIN:
          if (!ctl_pend_r)
          begin
            ftmr_r <= TMR_W'(LISTEN_CYCLES - 1);
            fst <= F_R_LISTEN;
          end
        F_R_LISTEN:
        begin
          if (rx_valid && rx_kind == K_JOIN_REPLY && pan_ok && !found_r &&
              rx_power >= floor_r)
          begin
            found_r <= 1'b1;
            found_chan_r <= chan_r;
            join_pan_r <= rx_pan;
          end
          if (ftmr_r == '0)
          begin
            chan_r <= next_chan(chans_r, chan_r);
            fst <= F_R_JOIN;
            if (next_chan(chans_r, chan_r) <= chan_r)
            begin
              // Scan pass complete
              found_r <= 1'b0;
              if (found_r)
              begin
                chan_r <= found_chan_r;
                fst <= F_R_REG;
              end
              else
                chan_r <= next_chan(chans_r, 4'hF);
            end
          end
        end
        F_R_REG:
          if (!ctl_pend_r)
          begin
            ftmr_r <= TMR_W'(LISTEN_CYCLES - 1);
            fst <= F_R_WAIT;
          end
        F_R_WAIT:
          if (rx_valid && rx_kind == K_REG_REPLY && mac_ok)
          begin
            node_addr_r <= rx_arg;
            linked_r <= 1'b1;
            fst <= F_R_LINKED;
          end
          else if ((rx_valid && rx_kind == K_REG_DENY && mac_ok) ||
                   ftmr_r == '0)
            fst <= F_OFF;
        F_R_LINKED: ;
      endcase
    end
  end

  // Duplicate filter on delivery of both directed and broadcast data frames
  assign rx_dup = last_vld_r && last_src_r == rx_src &&
                  last_seq_r == rx_seq;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_deliver <= 1'b0;
      rx_out_src <= 16'h0000;
      rx_out_arg <= 16'h0000;
      last_vld_r <= 1'b0;
      last_src_r <= 16'h0000;
      last_seq_r <= 8'h00;
    end
    else
    begin
      rx_deliver <= 1'b0;
      if (rx_valid && rx_kind == K_DATA && linked_r && !rx_dup &&
          (rx_dst == node_addr_r || rx_dst == BCAST_ADDR))
      begin
        rx_deliver <= 1'b1;
        rx_out_src <= rx_src;
        rx_out_arg <= rx_arg;
        last_vld_r <= 1'b1;
        last_src_r <= rx_src;
        last_seq_r <= rx_seq;
      end
    end
  end

  // Host notices: conflict or connection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      notice_valid <= 1'b0;
      notice_kind <= N_NONE;
      notice_chan <= 4'h0;
      notice_pan <= 16'h0000;
    end
    else
    begin
      notice_valid <= 1'b0;
      if (fst == F_B_LISTEN && rx_valid && rx_pan == pan_r && enabled &&
          !cfg_chg)
      begin
        notice_valid <= 1'b1;
        notice_kind <= N_CONFLICT;
        notice_chan <= chan_r;
        notice_pan <= rx_pan;
      end
      else if ((eng_ok && cur_kind_r == K_REG_REPLY) ||
               (fst == F_R_WAIT && rx_valid && rx_kind == K_REG_REPLY &&
                mac_ok && enabled && !cfg_chg))
      begin
        notice_valid <= 1'b1;
        notice_kind <= N_CONNECT;
        notice_chan <= chan_r;
        notice_pan <= is_base ? pan_r : join_pan_r;
      end
    end
  end

  assign host_tx_ok = eng_ok && cur_host_r;
  assign host_tx_fail = eng_fail && cur_host_r;
  assign phy_tx_kind = cur_kind_r;
  assign phy_tx_dst = cur_dst_r;
  assign phy_tx_src = node_addr_r;
  assign phy_tx_pan = is_base ? pan_r : join_pan_r;
  assign phy_tx_seq = cur_seq_r;
  assign phy_tx_arg = cur_arg_r;
  assign phy_tx_mac = cur_mac_r;
  assign phy_tx_relay = relay_r;
  assign chan_sel = chan_r;
  assign node_addr = node_addr_r;
  assign linked = linked_r;
endmodule
`default_nettype wire

/* File: test/snlc_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module snlc_assertions
  import snlc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_tx_req,
  input wire logic host_tx_ready,
  input wire logic host_tx_ok,
  input wire logic host_tx_fail,
  input wire logic cca_req,
  input wire logic cca_done,
  input wire logic cca_busy,
  input wire logic phy_tx_start,
  input wire logic rx_valid,
  input wire logic [2:0] rx_kind,
  input wire logic rx_deliver,
  input wire logic [15:0] node_addr,
  input wire logic notice_valid,
  input wire logic [1:0] notice_kind
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Sense request followed by its verdict
  sequence s_clear;
    cca_req ##1 (cca_done && !cca_busy);
  endsequence
  sequence s_busy;
    cca_req ##1 (cca_done && cca_busy);
  endsequence
  send_on_clear_a: assert property (s_clear |=> phy_tx_start)
    else $error("no send after clear channel");
  send_only_clear_a: assert property (
    phy_tx_start |-> $past(cca_done && !cca_busy))
    else $error("send without clear channel");
  busy_backoff_a: assert property (s_busy |=> !phy_tx_start && !cca_req)
    else $error("no backoff after busy channel");
  take_sense_a: assert property (host_tx_req && host_tx_ready |=> cca_req)
    else $error("accepted frame not sensed");
  addr_range_a: assert property (
    node_addr == 16'hFFFF || node_addr <= REM_ADDR_MAX)
    else $error("node address out of range");
  verdict_pulse_a: assert property (
    host_tx_ok || host_tx_fail |=> !(host_tx_ok || host_tx_fail))
    else $error("verdict longer than one cycle");
  conflict_cause_a: assert property (
    notice_valid && notice_kind == N_CONFLICT |-> $past(rx_valid))
    else $error("conflict notice without frame");
  deliver_cause_a: assert property (
    rx_deliver |-> $past(rx_valid && rx_kind == K_DATA))
    else $error("delivery without data frame");
endmodule
bind snlc_top snlc_assertions u_chk (.clk(clk), .rst_n(rst_n),
  .host_tx_req(host_tx_req), .host_tx_ready(host_tx_ready),
  .host_tx_ok(host_tx_ok), .host_tx_fail(host_tx_fail), .cca_req(cca_req),
  .cca_done(cca_done), .cca_busy(cca_busy), .phy_tx_start(phy_tx_start),
  .rx_valid(rx_valid), .rx_kind(rx_kind), .rx_deliver(rx_deliver),
  .node_addr(node_addr), .notice_valid(notice_valid),
  .notice_kind(notice_kind));
`default_nettype wire

/* File: test/snlc_radio_model.sv */
`timescale 1ns/100ps
`default_nettype none
module snlc_radio_model (
  input wire logic clk,
  input wire logic busy,
  input wire logic cca_req,
  output logic cca_done = 1'b0,
  output logic cca_busy = 1'b0,
  input wire logic phy_tx_start,
  output logic phy_tx_done = 1'b0
);
  logic [2:0] cnt = 3'h0;
  // Verdict a cycle after the request; toggles when unsampled
  always @(posedge clk)
  begin
    cca_done <= cca_req;
    cca_busy <= cca_req ? busy : ~cca_busy;
  end
  // Fixed air time; no acknowledgement ever comes back
  always @(posedge clk)
  begin
    phy_tx_done <= (cnt == 3'h1);
    if (phy_tx_start)
      cnt <= 3'h4;
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end
endmodule
`default_nettype wire

/* File: test/test_star_network_link_control.sv */
`timescale 1ns/100ps
`default_nettype none
module test_star_network_link_control;
  import snlc_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, req = 0, bz = 0, rv = 0;
  logic [3:0] ad = 4'h0;
  logic [15:0] wd = 16'h0, dst = 16'h0, rp = 16'h0, rq, na, np, oa;
  logic [7:0] sq = 8'h0;
  logic [7:0] ps;
  logic [2:0] rk = K_DATA;
  logic cq, cd, cb, st, dn, rdy, ok, fl, rl, lk, nv, dl;
  logic [1:0] nk;
  logic [3:0] ch;
  int fail_count = 0, n_checks = 0, cyc = 0, ns = 0, nr = 0, nd = 0;
  snlc_top #(.LISTEN_CYCLES(200), .ACK_CYCLES(50)) dut (.clk(clk),
    .rst_n(rst_n), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rq), .own_mac(64'h0), .host_tx_req(req), .host_tx_dst(dst),
    .host_tx_arg(wd), .host_tx_ready(rdy), .host_tx_ok(ok),
    .host_tx_fail(fl), .cca_req(cq), .cca_done(cd), .cca_busy(cb),
    .phy_tx_start(st), .phy_tx_kind(), .phy_tx_dst(), .phy_tx_src(),
    .phy_tx_pan(), .phy_tx_seq(ps), .phy_tx_arg(), .phy_tx_mac(),
    .phy_tx_relay(rl), .phy_tx_done(dn), .rx_valid(rv), .rx_kind(rk),
    .rx_src(dst), .rx_dst(dst), .rx_pan(rp), .rx_seq(sq), .rx_power(sq),
    .rx_arg(wd), .rx_mac(64'h0), .rx_deliver(dl), .rx_out_src(),
    .rx_out_arg(oa), .chan_sel(ch), .node_addr(na), .linked(lk),
    .notice_valid(nv), .notice_kind(nk), .notice_chan(), .notice_pan(np));
  snlc_radio_model rf (.clk(clk), .busy(bz), .cca_req(cq), .cca_done(cd),
    .cca_busy(cb), .phy_tx_start(st), .phy_tx_done(dn));
  always #50 clk = ~clk;
  // Frame counters and a guard against a hang
  always @(posedge clk)
  begin
    cyc++;
    if (st) ns++;
    if (st && rl) nr++;
    if (dl) nd++;
    if (cyc == 30000)
    begin
      fail_count++;
      complete_run;
    end
  end
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wreg(logic [3:0] a, logic [15:0] d);
    @(posedge clk) {wr, ad, wd} <= {1'b1, a, d};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rreg(logic [3:0] a, logic [15:0] e, string s);
    @(posedge clk) {rd, ad} <= {1'b1, a};
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) chk(s, e, rq);
  endtask
  // Request taken only while ready; counts start afresh
  task automatic go(logic [15:0] d);
    ns = 0;
    nr = 0;
    while (rdy !== 1'b1) @(negedge clk);
    @(posedge clk) {req, dst} <= {1'b1, d};
    @(posedge clk) req <= 1'b0;
  endtask
  task automatic fin;
    repeat (3000) if (ok !== 1'b1 && fl !== 1'b1) @(negedge clk);
  endtask
  task automatic t_form;
    rreg(RA_BREPS, 16'h0004, "bcast reps");
    rreg(4'hF, 16'h0000, "unmapped");
    wreg(RA_PAN, 16'h00A5);
    wreg(RA_CTRL, 16'h0005);
    repeat (20) @(posedge clk);
    {rv, rp} <= {1'b1, 16'h00A5};
    @(posedge clk) rv <= 1'b0;
    @(negedge clk) chk("notice", 16'h0005, {13'h0, nv, nk});
    chk("notice pan", 16'h00A5, np);
    repeat (300) @(posedge clk);
    chk("linked chan", 16'h0011, {11'h0, lk, ch});
    chk("base addr", BASE_ADDR, na);
    $display("formation test done");
  endtask
  task automatic t_bcast;
    @(posedge clk) bz <= 1'b1;
    go(BCAST_ADDR);
    repeat (40) @(posedge clk);
    chk("sends while busy", 16'h0000, ns[15:0]);
    bz <= 1'b0;
    fin;
    chk("bcast ok", 16'h0001, {15'h0, ok});
    chk("bcast copies", 16'h0004, ns[15:0]);
    $display("broadcast test done");
  endtask
  task automatic t_dir;
    go(16'h0005);
    fin;
    chk("fail", 16'h0001, {15'h0, fl});
    chk("tries", 16'h0006, ns[15:0]);
    chk("relay tries", 16'h0003, nr[15:0]);
    $display("directed test done");
  endtask
  // Far side answers the first copy with an ack echoing its sequence
  task automatic t_ack;
    go(16'h0005);
    while (dn !== 1'b1) @(negedge clk);
    @(posedge clk) {rv, rk, sq, dst} <= {1'b1, K_ACK, ps, BASE_ADDR};
    @(posedge clk) {rv, rk} <= {1'b0, K_DATA};
    @(negedge clk) chk("ack ok", 16'h0001, {15'h0, ok});
    chk("ack sends", 16'h0001, ns[15:0]);
    $display("acknowledge test done");
  endtask
  task automatic t_rx;
    nd = 0;
    @(posedge clk) {rv, dst, sq} <= {1'b1, BCAST_ADDR, 8'h07};
    @(posedge clk) rv <= 1'b0;
    @(posedge clk) rv <= 1'b1;
    @(posedge clk) rv <= 1'b0;
    repeat (3) @(posedge clk);
    chk("deliveries", 16'h0001, nd[15:0]);
    chk("deliver arg", 16'h0005, oa);
    $display("receive test done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_form;
    t_bcast;
    t_dir;
    t_ack;
    t_rx;
    complete_run;
  end
endmodule
`default_nettype wire
